// file: rtl/lbss_pkg.sv
// Shared types and constants for the local bus strobe and status block.
// Assumes one processor clock; all pin levels are resolved outside.
package lbss_pkg;

	// Cycle-type status codes driven on the three status outputs
	localparam logic [2:0] LBSS_CYC_INTA   = 3'h0;
	localparam logic [2:0] LBSS_CYC_IORD   = 3'h1;
	localparam logic [2:0] LBSS_CYC_IOWR   = 3'h2;
	localparam logic [2:0] LBSS_CYC_HALT   = 3'h3;
	localparam logic [2:0] LBSS_CYC_FETCH  = 3'h4;
	localparam logic [2:0] LBSS_CYC_MEMRD  = 3'h5;
	localparam logic [2:0] LBSS_CYC_MEMWR  = 3'h6;
	localparam logic [2:0] LBSS_CYC_PASSIV = 3'h7;

	// Queue operation codes, bit 1 on the write pin, bit 0 on latch pin
	localparam logic [1:0] LBSS_QOP_NONE   = 2'h0;
	localparam logic [1:0] LBSS_QOP_FIRST  = 2'h1;
	localparam logic [1:0] LBSS_QOP_EMPTY  = 2'h2;
	localparam logic [1:0] LBSS_QOP_NEXT   = 2'h3;

	// Reset values of the pin drivers
	localparam logic       LBSS_RST_LVL    = 1'h1;
	localparam logic       LBSS_RST_OE     = 1'h1;

	// Synchroniser width, one bit each for the ready and read-strap pins
	localparam int         LBSS_SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_T1,
		ST_T2,
		ST_T3,
		ST_TW,
		ST_T4,
		ST_HOLD
	} lbss_state_t;

	typedef enum logic [1:0] {
		PH_DRIVE,
		PH_FLOAT,
		PH_STRAP,
		PH_RUN
	} lbss_phase_t;

	typedef struct packed {
		logic lvl;
		logic oe;
	} lbss_pin_t;

	typedef struct packed {
		logic       valid;
		logic [2:0] ctype;
	} lbss_req_t;

	function automatic logic lbss_is_read(input logic [2:0] c);
		return (c == LBSS_CYC_IORD) || (c == LBSS_CYC_MEMRD) ||
			(c == LBSS_CYC_FETCH);
	endfunction

	function automatic logic lbss_is_write(input logic [2:0] c);
		return (c == LBSS_CYC_IOWR) || (c == LBSS_CYC_MEMWR);
	endfunction

endpackage

// file: rtl/lbss_sync2.sv
// Two-stage synchroniser for pin levels entering the processor clock.
// Assumes the inputs change at arbitrary times; output is stage two.
`timescale 1ns/1ps
module lbss_sync2
	import lbss_pkg::*;
#(
	parameter int WIDTH = 2
)(
	input  wire logic             i_mclk,
	input  wire logic             i_resetn,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_next;

	always_comb
	begin
		meta_next = i_async;
		sync_next = meta_reg;
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			meta_reg <= '0;
			o_sync   <= '0;
		end
		else
		begin
			meta_reg <= meta_next;
			o_sync   <= sync_next;
		end
	end

endmodule

// file: rtl/lbss_bus_ctrl.sv
// Bus-cycle sequencer: strobes, queue status, ready, lock, cycle status.
// Assumes requests, hold grant and queue ops come from logic on i_mclk;
// asynchronous ready and the read pin strap are raw pins.
`timescale 1ns/1ps
// Notes on behaviour
// - Write strobe low in T2, T3 and wait states of every write cycle outside queue mode.
// - Write strobe floats in hold; high one clock at reset, then floats.
// - Queue mode drives queue op bits: 00 none, 01/11 byte, 10 empty.
// - Read strobe low in T2, T3, TW of reads outside queue mode, never in T1.
// - Read strobe floats in hold and after reset pulse; pad pull-up.
// - Read pin sampled after reset; grounded pin selects queue mode.
// - Ready held high gives cycles with no wait states.
// - Cycle ends only once a ready input is active or ready is ignored; waits meanwhile.
// - Synchronous ready is used directly, without the two extra synchroniser clocks.
// - Lock output asserted low in response to a lock prefix.
// - Lock active from first data cycle T1 until instruction completes.
// - No prefetch cycles start while lock is asserted.
// - Status 000 inta, 001 io read, 010 io write, 011 halt.
module lbss_bus_ctrl
	import lbss_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	input  wire lbss_req_t  i_req,
	input  wire logic       i_hold_grant,
	input  wire logic       i_async_ready,
	input  wire logic       i_sync_ready,
	input  wire logic       i_ready_ignore,
	input  wire logic       i_rd_pin,
	input  wire logic [1:0] i_queue_op,
	input  wire logic       i_lock_prefix,
	input  wire logic       i_instr_done,
	output lbss_pin_t       o_wr,
	output lbss_pin_t       o_rd,
	output logic            o_le_q0,
	output logic [2:0]      o_status,
	output logic            o_status_oe,
	output logic            o_lock_n,
	output logic            o_req_ready,
	output logic            o_cycle_done,
	output logic            o_queue_mode
);

	lbss_state_t state_reg;
	lbss_state_t state_next;
	lbss_phase_t phase_reg;
	lbss_phase_t phase_next;
	logic        settle_reg;
	logic        settle_next;
	logic [2:0]  cyc_reg;
	logic [2:0]  cyc_next;
	logic        pend_reg;
	logic        pend_next;
	logic        lock_next;
	logic        qmode_next;
	lbss_pin_t   wr_next;
	lbss_pin_t   rd_next;
	logic        le_next;
	logic [2:0]  status_next;
	logic        status_oe_next;
	logic        ready_next;
	logic        done_next;
	logic [1:0]  sync_out;
	logic        async_ready_in_sync;
	logic        rd_sync;
	logic        bus_ready;
	logic        take;
	logic        active;

	// Ready pin and read-strap pin share one synchroniser
	lbss_sync2 #(
		.WIDTH (LBSS_SYNC_STAGES)
	) u_sync (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.i_async  ({i_async_ready, i_rd_pin}),
		.o_sync   (sync_out)
	);

	assign async_ready_in_sync = sync_out[1];
	assign rd_sync   = sync_out[0];

	// Sync ready is already on our clock, so it skips the synchroniser
	assign bus_ready = i_ready_ignore || async_ready_in_sync || i_sync_ready;

	// Fetches are refused while the lock output is low
	assign take = i_req.valid && o_req_ready && !i_hold_grant &&
		!(i_req.ctype == LBSS_CYC_FETCH && !o_lock_n);

	always_comb
	begin
		state_next = state_reg;
		phase_next = phase_reg;
		settle_next = settle_reg;
		cyc_next   = cyc_reg;
		qmode_next = o_queue_mode;
		done_next  = 1'b0;
		case (phase_reg)
			PH_DRIVE: phase_next = PH_FLOAT;
			// Two float clocks let the strap clear both synchroniser stages
			PH_FLOAT:
			begin
				settle_next = 1'b1;
				if (settle_reg)
					phase_next = PH_STRAP;
			end
			PH_STRAP:
			begin
				phase_next = PH_RUN;
				qmode_next = !rd_sync;
			end
			default: phase_next = PH_RUN;
		endcase
		case (state_reg)
			ST_IDLE:
				if (i_hold_grant)
					state_next = ST_HOLD;
				else if (take)
					state_next = ST_T1;
			ST_T1: state_next = ST_T2;
			ST_T2: state_next = ST_T3;
			ST_T3, ST_TW:
				state_next = bus_ready ? ST_T4 : ST_TW;
			ST_T4:
			begin
				done_next = 1'b1;
				if (take)
					state_next = ST_T1;
				else if (i_hold_grant)
					state_next = ST_HOLD;
				else
					state_next = ST_IDLE;
			end
			ST_HOLD:
				if (!i_hold_grant)
					state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
		if (take)
			cyc_next = i_req.ctype;
	end

	// Lock state: set wins over the instruction-done clear
	always_comb
	begin
		pend_next = pend_reg || i_lock_prefix;
		lock_next = !o_lock_n && !i_instr_done;
		if (state_next == ST_T1 && cyc_next != LBSS_CYC_FETCH &&
			pend_next && phase_reg == PH_RUN)
		begin
			lock_next = 1'b1;
			pend_next = 1'b0;
		end
	end

	// Pin values follow the next state, so each flop lines up with it
	always_comb
	begin
		active = (state_next == ST_T2) || (state_next == ST_T3) ||
			(state_next == ST_TW);
		wr_next        = '{lvl: 1'b1, oe: 1'b0};
		rd_next        = '{lvl: 1'b1, oe: 1'b0};
		le_next        = 1'b0;
		status_next    = LBSS_CYC_PASSIV;
		status_oe_next = 1'b0;
		if (phase_next == PH_RUN && state_next != ST_HOLD)
		begin
			status_oe_next = 1'b1;
			if (state_next == ST_T1 || active)
				status_next = cyc_next;
			if (qmode_next)
			begin
				wr_next = '{lvl: i_queue_op[1], oe: 1'b1};
				le_next = i_queue_op[0];
			end
			else
			begin
				wr_next = '{lvl: !(active && lbss_is_write(cyc_next)),
					oe: 1'b1};
				// Read stays high in T1 while the address is on the bus
				rd_next = '{lvl: !(active && lbss_is_read(cyc_next)),
					oe: 1'b1};
			end
		end
		// Otherwise both strobes float and the pad pull-up holds read high
		// A take only starts a cycle from idle or T4, so ready covers those
		ready_next = (phase_next == PH_RUN) &&
			((state_next == ST_IDLE) || (state_next == ST_T4));
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_reg    <= ST_IDLE;
			phase_reg    <= PH_DRIVE;
			settle_reg   <= 1'b0;
			cyc_reg      <= LBSS_CYC_PASSIV;
			pend_reg     <= 1'b0;
			o_lock_n     <= 1'b1;
			o_queue_mode <= 1'b0;
			o_wr         <= '{lvl: LBSS_RST_LVL, oe: LBSS_RST_OE};
			o_rd         <= '{lvl: LBSS_RST_LVL, oe: LBSS_RST_OE};
			o_le_q0      <= 1'b0;
			o_status     <= LBSS_CYC_PASSIV;
			o_status_oe  <= LBSS_RST_OE;
			o_req_ready  <= 1'b0;
			o_cycle_done <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			phase_reg    <= phase_next;
			settle_reg   <= settle_next;
			cyc_reg      <= cyc_next;
			pend_reg     <= pend_next;
			o_lock_n     <= !lock_next;
			o_queue_mode <= qmode_next;
			o_wr         <= wr_next;
			o_rd         <= rd_next;
			o_le_q0      <= le_next;
			o_status     <= status_next;
			o_status_oe  <= status_oe_next;
			o_req_ready  <= ready_next;
			o_cycle_done <= done_next;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	a_wr_strobe_low: assert property (
		(!o_queue_mode && lbss_is_write(cyc_reg) &&
		(state_reg inside {ST_T2, ST_T3, ST_TW}))
		|-> (!o_wr.lvl && o_wr.oe))
		else $error("write strobe not low in active write state");

	a_reset_pulse: assert property (
		(phase_reg == PH_DRIVE) |-> (o_wr.oe && o_wr.lvl && o_rd.oe)
		##1 (!o_wr.oe && !o_rd.oe) [*2])
		else $error("strobes not driven high then floated after reset");

	a_hold_float: assert property (
		(state_reg == ST_HOLD) |-> (!o_wr.oe && !o_rd.oe && !o_status_oe))
		else $error("pins driven while bus is held");

	a_queue_bits: assert property (
		(o_queue_mode && state_reg != ST_HOLD && phase_reg == PH_RUN &&
		$past(o_queue_mode)) |->
		(o_wr.lvl == $past(i_queue_op[1]) &&
		o_le_q0 == $past(i_queue_op[0]) && !o_rd.oe))
		else $error("queue status bits wrong");

	a_rd_strobe: assert property (
		(!o_queue_mode && state_reg == ST_T1) ##1
		(state_reg == ST_T2 && lbss_is_read(cyc_reg))
		|-> ($past(o_rd.lvl) && !o_rd.lvl))
		else $error("read strobe timing wrong");

	a_mode_strap: assert property (
		(phase_reg == PH_STRAP) |=> (o_queue_mode == !$past(rd_sync)))
		else $error("queue mode not taken from read pin strap");

	a_no_wait: assert property (
		(state_reg == ST_T3 && i_sync_ready) |=> (state_reg == ST_T4))
		else $error("wait state inserted while ready high");

	a_wait_insert: assert property (
		((state_reg inside {ST_T3, ST_TW}) && !bus_ready)
		|=> (state_reg == ST_TW))
		else $error("cycle ended without ready");

	a_lock_start: assert property (
		$fell(o_lock_n) |->
		(state_reg == ST_T1 && cyc_reg != LBSS_CYC_FETCH))
		else $error("lock asserted outside a data T1");

	a_lock_stay: assert property (
		(!o_lock_n && !i_instr_done) |=> !o_lock_n)
		else $error("lock released before instruction done");

	a_no_prefetch: assert property (
		(!o_lock_n && i_req.valid && i_req.ctype == LBSS_CYC_FETCH)
		|=> (state_reg != ST_T1))
		else $error("prefetch taken under lock");

	a_status_code: assert property (
		(phase_reg == PH_RUN && state_reg == ST_IDLE) |-> 
		(o_status == LBSS_CYC_PASSIV && o_status_oe))
		else $error("cycle status code wrong");

	a_status_type: assert property (
		(state_reg inside {ST_T1, ST_T2, ST_T3, ST_TW}) |->
		(o_status == cyc_reg && o_status_oe))
		else $error("status does not show cycle type");

	c_write_wait: cover property (
		(state_reg == ST_TW && lbss_is_write(cyc_reg)) ##1
		(state_reg == ST_T4));
	c_read_fast: cover property (
		(state_reg == ST_T3 && lbss_is_read(cyc_reg)) ##1
		(state_reg == ST_T4));
	c_lock_seq: cover property ($fell(o_lock_n) ##[1:20] $rose(o_lock_n));
	c_queue_mode: cover property (o_queue_mode && phase_reg == PH_RUN);

endmodule

// file: sim/lbss_mem_model.sv
// Memory and I/O partner: raises ready after a chosen count of wait states.
// Assumes status 3'h7 means no cycle; everything runs on i_mclk.
`timescale 1ns/1ps
module lbss_mem_model
	import lbss_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	input  wire logic [2:0] i_status,
	input  wire logic [3:0] i_waits,
	input  wire logic       i_use_async,
	output logic            o_async_ready,
	output logic            o_sync_ready
);
	logic [3:0] cnt_reg;
	logic       rdy;
	logic       busy;
	assign busy = (i_status != LBSS_CYC_PASSIV);
	always_ff @(posedge i_mclk or negedge i_resetn)
		if (!i_resetn)
			cnt_reg <= 4'h0;
		else
			cnt_reg <= busy ? cnt_reg + 4'h1 : 4'h0;
	// Built from flops only, so both edges land just after a clock edge
	assign rdy = busy && (cnt_reg >= i_waits + 4'h2);
	assign o_async_ready = i_use_async & rdy;
	assign o_sync_ready = !i_use_async & rdy;
endmodule

// file: sim/tb.sv
// Self-checking bench for the bus strobe and status sequencer.
// Assumes the partner model answers ready; the bench drives the rest.
`timescale 1ns/1ps
`define CHK(a, b, m) \
	begin \
		num_checks++; \
		if ((a) !== (b)) \
		begin \
			num_errors++; \
			$display("ERROR %0t %s", $time, m); \
		end \
	end
module tb
	import lbss_pkg::*;
;
	logic       clk = 0;
	logic       rstn = 0;
	lbss_req_t  req = '0;
	logic       hold = 0, ign = 0, pfx = 0, idone = 0, use_async = 0;
	logic [1:0] qop = 2'h0;
	logic [3:0] waits = 4'h0;
	logic       strap = 1;
	lbss_pin_t  wr, rd;
	logic       le, st_oe, lock_n, rq_rdy, done, qmode, async_ready_in, sync_ready_in;
	logic [2:0] st;
	wire logic  rd_pin;
	int         num_errors = 0;
	int         num_checks = 0;
	int         w;
	logic [1:0] q;
	// Read pin resolves to the strap level whenever nobody drives it
	assign rd_pin = rd.oe ? rd.lvl : strap;
	always #20 clk = ~clk;
	lbss_bus_ctrl DUT (.i_mclk(clk), .i_resetn(rstn), .i_req(req),
		.i_hold_grant(hold), .i_async_ready(async_ready_in), .i_sync_ready(sync_ready_in),
		.i_ready_ignore(ign), .i_rd_pin(rd_pin), .i_queue_op(qop),
		.i_lock_prefix(pfx), .i_instr_done(idone), .o_wr(wr), .o_rd(rd),
		.o_le_q0(le), .o_status(st), .o_status_oe(st_oe),
		.o_lock_n(lock_n), .o_req_ready(rq_rdy), .o_cycle_done(done),
		.o_queue_mode(qmode));
	lbss_mem_model MEM (.i_mclk(clk), .i_resetn(rstn), .i_status(st),
		.i_waits(waits), .i_use_async(use_async), .o_async_ready(async_ready_in),
		.o_sync_ready(sync_ready_in));
	function automatic int strobes(input logic [2:0] c, input logic wside,
		input int ew);
		logic is_w;
		is_w = (c == LBSS_CYC_IOWR) || (c == LBSS_CYC_MEMWR);
		if (wside)
			return is_w ? 2 + ew : 0;
		return (!is_w && c != LBSS_CYC_INTA && c != LBSS_CYC_HALT) ? 2 + ew : 0;
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic rst(input logic s);
		@(posedge clk);
		strap <= s;
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		`CHK({wr, rd}, 4'hf, "reset drive")
		@(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		`CHK({wr.oe, rd.oe, st_oe}, 3'h0, "float after reset")
		// Strap settles through two float clocks and the synchroniser
		repeat (3) @(posedge clk);
		@(negedge clk);
		`CHK(qmode, !s, "mode strap")
	endtask
	// One bus cycle: w is the model's delay, ew the expected wait states
	task automatic bus(input logic [2:0] c, input int w, input logic ua,
		input int ew, input logic lk);
		int n, k, lw, lr;
		n = 0;
		k = 0;
		lw = 0;
		lr = 0;
		@(posedge clk);
		waits <= w[3:0];
		use_async <= ua;
		req <= '{1'b1, c};
		@(negedge clk);
		while (rq_rdy !== 1'b1 && k < 20)
		begin
			@(negedge clk);
			k++;
		end
		@(posedge clk);
		req <= '0;
		while (done !== 1'b1 && n < 30)
		begin
			@(negedge clk);
			n++;
			if (n == 1)
				`CHK({lock_n, st}, {lk, c}, "status or lock")
			lw += (wr.lvl === 1'b0);
			lr += (rd.lvl === 1'b0);
		end
		if (k >= 20 || n >= 30)
		begin
			num_errors++;
			$display("ERROR %0t bus cycle hung", $time);
			tally_and_finish();
		end
		`CHK(n, 5 + ew, "cycle length")
		`CHK(lw, strobes(c, 1'b1, ew), "write strobe")
		`CHK(lr, strobes(c, 1'b0, ew), "read strobe")
	endtask
	initial
	begin
		w = $urandom(32'h0000_0a62);
		rst(1'b1);
		for (int c = 0; c < 7; c++)
		begin
			w = $urandom_range(3);
			bus(c[2:0], w, 1'b0, w, 1'b1);
		end
		for (int i = 0; i < 3; i++)
			bus(LBSS_CYC_MEMRD, i, 1'b1, i + 2, 1'b1);
		@(posedge clk);
		ign <= 1'b1;
		bus(LBSS_CYC_IOWR, 13, 1'b0, 0, 1'b1);
		@(posedge clk);
		ign <= 1'b0;
		$display("test cycles done");
		@(posedge clk);
		pfx <= 1'b1;
		@(posedge clk);
		pfx <= 1'b0;
		bus(LBSS_CYC_MEMWR, 0, 1'b0, 0, 1'b0);
		@(posedge clk);
		req <= '{1'b1, LBSS_CYC_FETCH};
		repeat (8) @(negedge clk);
		`CHK({lock_n, st}, {1'b0, LBSS_CYC_PASSIV}, "locked fetch")
		@(posedge clk);
		req <= '0;
		idone <= 1'b1;
		@(posedge clk);
		idone <= 1'b0;
		@(negedge clk);
		`CHK(lock_n, 1'b1, "lock release")
		bus(LBSS_CYC_FETCH, 0, 1'b0, 0, 1'b1);
		$display("test lock done");
		@(posedge clk);
		hold <= 1'b1;
		repeat (3) @(negedge clk);
		`CHK({wr.oe, rd.oe, st_oe, rd_pin}, 4'h1, "hold float")
		@(posedge clk);
		hold <= 1'b0;
		bus(LBSS_CYC_MEMRD, 1, 1'b0, 1, 1'b1);
		$display("test hold done");
		rst(1'b0);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			q = (i < 4) ? i[1:0] : 2'($urandom);
			qop <= q;
			@(posedge clk);
			@(negedge clk);
			`CHK({rd.oe, wr.lvl, le}, {1'b0, q}, "queue status")
		end
		$display("test queue done");
		tally_and_finish();
	end
endmodule
